// >>> design/vrc_top.sv
// The implementer's own choice: the AHB-Lite interface to the registers.
`timescale 1ns/1ps
module vrc_top (
  // Clock and reset
  input  wire logic              i_clock,
  input  wire logic              i_rst_b,
  // AHB-Lite slave
  input  wire logic              i_hsel,
  input  wire logic [9:0]        i_haddr,
  input  wire logic [1:0]        i_htrans,
  input  wire logic              i_hwrite,
  input  wire logic [2:0]        i_hsize,
  input  wire logic [31:0]       i_hwdata,
  input  wire logic              i_hready,
  output logic      [31:0]       o_hrdata,
  output logic                   o_hreadyout,
  output logic                   o_hresp,
  // Peripheral enables from other blocks
  input  wire vrc_pkg::vrc_periph_t i_periph,
  // Analog controls
  output vrc_pkg::vrc_analog_t   o_analog
);

  vrc_pkg::vrc_periph_t periph_s;
  logic [3:0]           periph_sync;

  // Peripheral enables cross in from other domains
  vrc_sync u_sync (
    .i_clock (i_clock),
    .i_rst_b (i_rst_b),
    .i_async (i_periph),
    .o_sync  (periph_sync)
  );
  assign periph_s = periph_sync;

  // Bus address phase capture
  logic       wr_pend;
  logic       rd_pend;
  logic [9:0] addr_q;
  logic       next_wr_pend;
  logic       next_rd_pend;
  logic [9:0] next_addr_q;
  logic       take;

  // Only whole-word NONSEQ transfers are accepted
  assign take = i_hsel && i_hready && (i_htrans == vrc_pkg::HTRANS_NONSEQ)
                && (i_hsize == vrc_pkg::HSIZE_WORD);

  always_comb begin
    next_wr_pend = take && i_hwrite;
    next_rd_pend = take && !i_hwrite;
    next_addr_q  = take ? i_haddr : addr_q;
  end

  always_ff @(posedge i_clock) begin
    if (!i_rst_b) begin
      wr_pend <= 1'b0;
      rd_pend <= 1'b0;
      addr_q  <= 10'h000;
    end else begin
      wr_pend <= next_wr_pend;
      rd_pend <= next_rd_pend;
      addr_q  <= next_addr_q;
    end
  end

  // Control register
  logic [7:0] ref_ctrl;
  logic [7:0] next_ref_ctrl;

  // Write data is taken in the data phase
  always_comb begin
    next_ref_ctrl = ref_ctrl;
    if (wr_pend && addr_q == vrc_pkg::REF_CTRL_ADDR) begin
      next_ref_ctrl = i_hwdata[7:0] & vrc_pkg::REF_CTRL_MASK;
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_rst_b) begin
      ref_ctrl <= vrc_pkg::REF_CTRL_RESET;
    end else begin
      ref_ctrl <= next_ref_ctrl;
    end
  end

  // Read data, registered for the data phase
  logic [31:0] rdata;
  logic [31:0] next_rdata;

  always_comb begin
    next_rdata = 32'h0000_0000;
    if (take && !i_hwrite) begin
      unique case (i_haddr)
        vrc_pkg::REF_CTRL_ADDR:  next_rdata = {24'h00_0000, next_ref_ctrl};
        vrc_pkg::FORCE_STS_ADDR: next_rdata = {28'h000_0000, periph_s};
        default:                 next_rdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_rst_b) begin
      rdata <= 32'h0000_0000;
    end else begin
      rdata <= next_rdata;
    end
  end

  // Bus response: zero wait states, always OKAY
  logic bus_ready;
  logic bus_resp;
  logic next_bus_ready;
  logic next_bus_resp;

  always_comb begin
    next_bus_ready = 1'b1;
    next_bus_resp  = 1'b0;
  end

  always_ff @(posedge i_clock) begin
    if (!i_rst_b) begin
      bus_ready <= 1'b1;
      bus_resp  <= 1'b0;
    end else begin
      bus_ready <= next_bus_ready;
      bus_resp  <= next_bus_resp;
    end
  end

  assign o_hrdata    = rdata;
  assign o_hreadyout = bus_ready;
  assign o_hresp     = bus_resp;

  // Analog control outputs
  vrc_pkg::vrc_analog_t analog;
  vrc_pkg::vrc_analog_t next_analog;

  always_comb begin
    next_analog.ref_source_select  = next_ref_ctrl[vrc_pkg::REF_SOURCE_SELECT_BIT];
    next_analog.temp_sensor_enable = next_ref_ctrl[vrc_pkg::TEMP_SENSOR_ENABLE_BIT];
    next_analog.temp_sensor_drive  = next_ref_ctrl[vrc_pkg::TEMP_SENSOR_ENABLE_BIT];
    next_analog.converter_bias_enable =
      next_ref_ctrl[vrc_pkg::ANALOG_BIAS_ENABLE_BIT]
      | periph_s.converter_zero_enable | periph_s.int_osc_enable;
    next_analog.ref_bias_enable = periph_s.int_vref_enable
      | next_ref_ctrl[vrc_pkg::TEMP_SENSOR_ENABLE_BIT] | periph_s.clock_mult_enable;
    next_analog.ref_buffer_enable = next_ref_ctrl[vrc_pkg::REF_BUFFER_ENABLE_BIT];
  end

  always_ff @(posedge i_clock) begin
    if (!i_rst_b) begin
      analog <= '0;
    end else begin
      analog <= next_analog;
    end
  end

  assign o_analog = analog;

  // Checks on the outputs and the register
  a_force_bias: assert property (@(posedge i_clock) disable iff (!i_rst_b)
    (periph_s.converter_zero_enable || periph_s.int_osc_enable)
    |=> analog.converter_bias_enable)
    else $error("converter bias not forced");
  a_ref_bias_auto: assert property (@(posedge i_clock) disable iff (!i_rst_b)
    (periph_s.int_vref_enable || periph_s.clock_mult_enable)
    |=> analog.ref_bias_enable)
    else $error("reference bias not enabled");
  a_sensor_bias: assert property (@(posedge i_clock) disable iff (!i_rst_b)
    analog.temp_sensor_enable
    |-> analog.ref_bias_enable)
    else $error("reference bias off while sensor on");
  a_upper_zero: assert property (@(posedge i_clock) disable iff (!i_rst_b)
    ref_ctrl[7:4] == 4'h0)
    else $error("upper bits not zero");
  a_read_value: assert property (@(posedge i_clock) disable iff (!i_rst_b)
    (rd_pend && addr_q == vrc_pkg::REF_CTRL_ADDR)
    |-> rdata == {24'h00_0000, ref_ctrl})
    else $error("read data differs from register");
  a_read_idle: assert property (@(posedge i_clock) disable iff (!i_rst_b)
    !rd_pend
    |-> rdata == 32'h0000_0000)
    else $error("read data outside data phase");
  a_write_follow: assert property (@(posedge i_clock) disable iff (!i_rst_b)
    (wr_pend && addr_q == vrc_pkg::REF_CTRL_ADDR)
    |=> analog.ref_source_select == $past(i_hwdata[vrc_pkg::REF_SOURCE_SELECT_BIT])
    && analog.ref_buffer_enable == $past(i_hwdata[vrc_pkg::REF_BUFFER_ENABLE_BIT]))
    else $error("outputs did not follow write");
  a_bias_manual: assert property (@(posedge i_clock) disable iff (!i_rst_b)
    (!periph_s.converter_zero_enable && !periph_s.int_osc_enable)
    |=> analog.converter_bias_enable == ref_ctrl[vrc_pkg::ANALOG_BIAS_ENABLE_BIT])
    else $error("manual bias mismatch");
  a_sensor_drive: assert property (@(posedge i_clock) disable iff (!i_rst_b)
    analog.temp_sensor_drive == ref_ctrl[vrc_pkg::TEMP_SENSOR_ENABLE_BIT])
    else $error("sensor drive mismatch");
  a_source_sel: assert property (@(posedge i_clock) disable iff (!i_rst_b)
    analog.ref_source_select == ref_ctrl[vrc_pkg::REF_SOURCE_SELECT_BIT])
    else $error("source select mismatch");
  a_buffer_en: assert property (@(posedge i_clock) disable iff (!i_rst_b)
    analog.ref_buffer_enable == ref_ctrl[vrc_pkg::REF_BUFFER_ENABLE_BIT])
    else $error("buffer enable mismatch");
  a_bus_okay: assert property (@(posedge i_clock) disable iff (!i_rst_b)
    bus_ready && !bus_resp)
    else $error("bus not ready or not okay");

  // Main scenarios
  c_write: cover property (@(posedge i_clock) wr_pend && addr_q == vrc_pkg::REF_CTRL_ADDR);
  c_read: cover property (@(posedge i_clock) rd_pend && addr_q == vrc_pkg::REF_CTRL_ADDR);
  c_forced: cover property (@(posedge i_clock) analog.converter_bias_enable && !ref_ctrl[1]);
  c_auto_bias: cover property (@(posedge i_clock)
    analog.ref_bias_enable && !analog.temp_sensor_enable);
  c_supply_ref: cover property (@(posedge i_clock) analog.ref_source_select);

endmodule : vrc_top

// >>> design/vrc_pkg.sv
package vrc_pkg;

  // Register map: word index, byte address is four times the index
  localparam logic [7:0] REF_CTRL_OFS   = 8'hD1;
  localparam logic [7:0] FORCE_STS_OFS  = 8'hD2;
  localparam logic [9:0] REF_CTRL_ADDR  = {REF_CTRL_OFS, 2'h0};
  localparam logic [9:0] FORCE_STS_ADDR = {FORCE_STS_OFS, 2'h0};

  // Field positions of reference_control
  localparam int REF_BUFFER_ENABLE_BIT  = 0;
  localparam int ANALOG_BIAS_ENABLE_BIT = 1;
  localparam int TEMP_SENSOR_ENABLE_BIT = 2;
  localparam int REF_SOURCE_SELECT_BIT  = 3;

  localparam logic [7:0] REF_CTRL_RESET = 8'h00;
  localparam logic [7:0] REF_CTRL_MASK  = 8'h0F;

  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [2:0] HSIZE_WORD    = 3'h2;

  // Analog control outputs
  typedef struct packed {
    logic ref_source_select;
    logic temp_sensor_enable;
    logic temp_sensor_drive;
    logic converter_bias_enable;
    logic ref_bias_enable;
    logic ref_buffer_enable;
  } vrc_analog_t;

  // Peripheral enable inputs
  typedef struct packed {
    logic converter_zero_enable;
    logic int_osc_enable;
    logic int_vref_enable;
    logic clock_mult_enable;
  } vrc_periph_t;

endpackage : vrc_pkg

// >>> design/vrc_sync.sv
`timescale 1ns/1ps
module vrc_sync (
  // Clock and reset
  input  wire logic       i_clock,
  input  wire logic       i_rst_b,
  // Asynchronous levels
  input  wire logic [3:0] i_async,
  // Synchronised levels
  output logic      [3:0] o_sync
);

  logic [3:0] stage1;
  logic [3:0] stage2;

  always_ff @(posedge i_clock) begin
    if (!i_rst_b) begin
      stage1 <= 4'h0;
      stage2 <= 4'h0;
    end else begin
      stage1 <= i_async;
      stage2 <= stage1;
    end
  end

  assign o_sync = stage2;

endmodule : vrc_sync

// >>> verif/testbench.sv
`timescale 1ns/1ps
module testbench;
  typedef struct packed {
    logic [31:0] wdata;
    logic [3:0]  periph;
    logic [5:0]  analog;
  } vrc_row_t;
  logic                 i_clock;
  logic                 i_rst_b;
  logic                 i_hsel;
  logic                 i_hwrite;
  logic [9:0]           i_haddr;
  logic [1:0]           i_htrans;
  logic [2:0]           i_hsize;
  logic [31:0]          i_hwdata;
  logic [31:0]          o_hrdata;
  logic [31:0]          rd;
  logic                 o_hreadyout;
  logic                 o_hresp;
  vrc_pkg::vrc_periph_t i_periph;
  vrc_pkg::vrc_analog_t o_analog;
  int                   fail_count;
  int                   tests_run;
  vrc_row_t             rows [10];

  vrc_top dut (.i_clock(i_clock), .i_rst_b(i_rst_b), .i_hsel(i_hsel), .i_haddr(i_haddr),
    .i_htrans(i_htrans), .i_hwrite(i_hwrite), .i_hsize(i_hsize), .i_hwdata(i_hwdata),
    .i_hready(o_hreadyout), .o_hrdata(o_hrdata), .o_hreadyout(o_hreadyout),
    .o_hresp(o_hresp), .i_periph(i_periph), .o_analog(o_analog));

  task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected %s: expected %h seen %h", name, exp, seen);
    end
  endtask : check

  // One single transfer, entered just after a rising edge
  task bus(input logic wr, input logic [9:0] a, input logic [31:0] d, input logic [2:0] sz);
    i_hsel   <= 1'b1;
    i_htrans <= vrc_pkg::HTRANS_NONSEQ;
    i_haddr  <= a;
    i_hwrite <= wr;
    i_hsize  <= sz;
    do @(posedge i_clock); while (o_hreadyout !== 1'b1);
    i_hsel   <= 1'b0;
    i_htrans <= 2'h0;
    i_hwdata <= d;
    do @(posedge i_clock); while (o_hreadyout !== 1'b1);
    rd = o_hrdata;
    check("hresp", {31'h0, o_hresp}, 32'h0);
  endtask : bus

  task print_verdict;
    if (fail_count == 0 && tests_run > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : print_verdict

  initial begin
    i_clock = 1'b0;
    forever #50 i_clock = ~i_clock;
  end

  initial begin
    repeat (3000) @(posedge i_clock);
    fail_count++;
    print_verdict();
  end

  initial begin
    {i_rst_b, i_hsel, i_hwrite, i_haddr, i_htrans, i_hsize, i_hwdata} = '0;
    i_periph = '0;
    fail_count = 0;
    tests_run = 0;
    rows = '{'{32'h01, 4'h0, 6'h01}, '{32'h02, 4'h0, 6'h04}, '{32'h04, 4'h0, 6'h1A},
      '{32'h08, 4'h0, 6'h20}, '{32'h00, 4'h8, 6'h04}, '{32'h00, 4'h4, 6'h04},
      '{32'h00, 4'h2, 6'h02}, '{32'h00, 4'h1, 6'h02}, '{32'hFFFFFFF0, 4'h0, 6'h00},
      '{32'h0F, 4'h0, 6'h3F}};
    repeat (6) @(posedge i_clock);
    check("reset analog", {26'h0, o_analog}, 32'h0);
    i_rst_b <= 1'b1;
    foreach (rows[k]) begin
      i_periph <= rows[k].periph;
      bus(1'b1, vrc_pkg::REF_CTRL_ADDR, rows[k].wdata, vrc_pkg::HSIZE_WORD);
      repeat (3) @(posedge i_clock);
      check("analog", {26'h0, o_analog},
            {26'h0, rows[k].analog});
      bus(1'b0, vrc_pkg::REF_CTRL_ADDR, 32'h0, vrc_pkg::HSIZE_WORD);
      check("readback", rd, rows[k].wdata & 32'h0F);
      bus(1'b0, vrc_pkg::FORCE_STS_ADDR, 32'h0, vrc_pkg::HSIZE_WORD);
      check("status", rd, {28'h0, rows[k].periph});
    end
    // Byte write and unmapped write must leave the register alone
    bus(1'b1, vrc_pkg::REF_CTRL_ADDR, 32'h0, 3'h0);
    bus(1'b1, 10'h34C, 32'h0, vrc_pkg::HSIZE_WORD);
    bus(1'b0, 10'h34C, 32'h0, vrc_pkg::HSIZE_WORD);
    check("unmapped", rd, 32'h0);
    bus(1'b0, vrc_pkg::REF_CTRL_ADDR, 32'h0, vrc_pkg::HSIZE_WORD);
    check("after ignored", rd, 32'h0F);
    // Second reset in mid-run
    i_rst_b <= 1'b0;
    repeat (2) @(posedge i_clock);
    i_rst_b <= 1'b1;
    @(posedge i_clock);
    check("rerst analog", {26'h0, o_analog}, 32'h0);
    bus(1'b0, vrc_pkg::REF_CTRL_ADDR, 32'h0, vrc_pkg::HSIZE_WORD);
    check("rerst read", rd, {24'h0, vrc_pkg::REF_CTRL_RESET});
    print_verdict();
  end
endmodule : testbench
